// ### pkg/dma_chan_pkg.sv
// Shared constants, field layouts and carrier types of the channel register front end
package dma_chan_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W   = 32;
    localparam int DATA_W   = 32;
    localparam int HALF_W   = 16;
    localparam int IDX_W    = 3;
    localparam int ALIGN_W  = 2;
    localparam int SEL_W    = 8;

    // ------------------------------------------------------------
    // Register offsets and indices
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CONTROL   = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] OFS_RESERVED  = 32'h0000_0008;
    localparam logic [ADDR_W-1:0] OFS_CMD_PTR   = 32'h0000_000c;
    localparam logic [ADDR_W-1:0] OFS_INT_SEL   = 32'h0000_0010;
    localparam logic [ADDR_W-1:0] OFS_BRANCH_SEL = 32'h0000_0014;
    localparam logic [ADDR_W-1:0] OFS_WAIT_SEL  = 32'h0000_0018;
    localparam logic [ADDR_W-1:0] REG_WINDOW    = 32'h0000_001c;

    localparam logic [IDX_W-1:0]  IDX_CONTROL    = OFS_CONTROL[IDX_W+1:ALIGN_W];
    localparam logic [IDX_W-1:0]  IDX_STATUS     = OFS_STATUS[IDX_W+1:ALIGN_W];
    localparam logic [IDX_W-1:0]  IDX_RESERVED   = OFS_RESERVED[IDX_W+1:ALIGN_W];
    localparam logic [IDX_W-1:0]  IDX_CMD_PTR    = OFS_CMD_PTR[IDX_W+1:ALIGN_W];
    localparam logic [IDX_W-1:0]  IDX_INT_SEL    = OFS_INT_SEL[IDX_W+1:ALIGN_W];
    localparam logic [IDX_W-1:0]  IDX_BRANCH_SEL = OFS_BRANCH_SEL[IDX_W+1:ALIGN_W];
    localparam logic [IDX_W-1:0]  IDX_WAIT_SEL   = OFS_WAIT_SEL[IDX_W+1:ALIGN_W];

    // ------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------
    localparam int BIT_GO    = 15;
    localparam int BIT_HOLD  = 14;
    localparam int BIT_FLUSH = 13;
    localparam int BIT_WAKE  = 12;
    localparam int BIT_FATAL = 11;
    localparam int BIT_EXEC  = 10;
    localparam int BIT_BT    = 8;
    localparam int MASK_LSB  = 16;

    localparam logic [HALF_W-1:0] SW_FREE_MASK     = 16'hc0ff;
    localparam logic [HALF_W-1:0] SW_SET_ONLY_MASK = 16'h3000;
    localparam logic [HALF_W-1:0] STATUS_RESET     = 16'h0000;
    localparam logic [HALF_W-1:0] STATUS_PAD       = 16'h0000;
    localparam logic [DATA_W-1:0] ZERO_WORD        = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PTR_ALIGN_MASK   = 32'hffff_fff0;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic fetch_done;
        logic flush_done;
        logic stop_done;
        logic fatal;
        logic branch_done;
        logic branch_taken;
    } engine_evt_t;

    typedef enum logic [1:0] {
        CH_STOPPED = 2'h0,
        CH_RUNNING = 2'h1,
        CH_PAUSED  = 2'h3,
        CH_IDLE    = 2'h2
    } chan_state_t;

endpackage

// ### logic/offset_decoder.sv
// Address to channel register index decoder
`timescale 1ns/1ps
module offset_decoder
    import dma_chan_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [ADDR_W-1:0] base,
    input  wire logic              bare_offset,
    output logic                   hit,
    output logic [IDX_W-1:0]       idx
);

    logic [ADDR_W-1:0] ofs;

    always_comb begin
        // RULE_02 bare offset
        // RULE_03 base plus offset
        ofs = bare_offset ? addr : addr - base;
        // RULE_14 window only
        hit = (ofs < REG_WINDOW) && (ofs[ALIGN_W-1:0] == '0);
        idx = ofs[IDX_W+ALIGN_W-1:ALIGN_W];
    end

endmodule

// ### logic/masked_update.sv
// Masked update of the software controllable status bits
`timescale 1ns/1ps
module masked_update
    import dma_chan_pkg::*;
(
    input  wire logic [HALF_W-1:0] cur,
    input  wire logic [HALF_W-1:0] write_bit_mask,
    input  wire logic [HALF_W-1:0] write_bit_values,
    output logic [HALF_W-1:0]      nxt
);

    logic [HALF_W-1:0] eff;

    always_comb begin
        // RULE_11 limited bits
        eff = (write_bit_mask & SW_FREE_MASK)
            | (write_bit_mask & write_bit_values & SW_SET_ONLY_MASK);
        // RULE_07 copy masked bits
        nxt = (cur & ~eff) | (write_bit_values & eff);
    end

endmodule

// ### logic/dma_channel_regs.sv
// Channel register front end with host and command processor access
`timescale 1ns/1ps

// Summary of operation
// RULE_01 - Decode seven channel register offsets
// RULE_02 - Register-space commands use bare offsets
// RULE_03 - Host and system commands add base
// RULE_04 - Status resets zero; control reads zero
// RULE_05 - Pointer stored when idle; selects always
// RULE_06 - Upper control half is bit mask
// RULE_07 - Masked data bits copied into status
// RULE_08 - Software changes status only via control
// RULE_09 - Control bits readable in status word
// RULE_10 - Status word writes are discarded
// RULE_11 - Read-only and one-way bits protected
// RULE_12 - Status exposed; upper half zero
// RULE_13 - Pointer holds command list location
// RULE_14 - Device registers lie outside decode
// RULE_15 - Reserved slot reads zero, ignores writes
// RULE_16 - Go bit starts, clearing aborts
// RULE_17 - Hold bit suspends, clears executing
// RULE_18 - Wake refetches; cleared after fetch
// RULE_19 - Fatal halt cleared when go cleared
module dma_channel_regs
    import dma_chan_pkg::*;
#(
    parameter logic [ADDR_W-1:0] CHANNEL_BASE = 32'h0000_0000
)
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic              host_sel,
    input  wire reg_req_t          host_req,
    output logic [DATA_W-1:0]      host_rdata,
    output logic                   host_ack,
    input  wire logic              cmd_sel,
    input  wire logic              cmd_regs_space,
    input  wire reg_req_t          cmd_req,
    output logic [DATA_W-1:0]      cmd_rdata,
    output logic                   cmd_ack,
    input  wire engine_evt_t       eng_evt,
    output logic [HALF_W-1:0]      status_bits,
    output logic                   executing_flag,
    output logic [DATA_W-1:0]      command_list_pointer_low,
    output logic [DATA_W-1:0]      interrupt_condition_select,
    output logic [DATA_W-1:0]      branch_condition_select,
    output logic [DATA_W-1:0]      wait_condition_select
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic              host_hit;
    logic [IDX_W-1:0]  host_idx;
    logic              cmd_hit;
    logic [IDX_W-1:0]  cmd_idx;
    logic              host_take;
    logic              cmd_take;
    logic              acc_take;
    logic              acc_wr;
    logic [IDX_W-1:0]  acc_idx;
    logic [DATA_W-1:0] acc_wdata;
    logic              ctrl_write;
    logic              ptr_write;
    logic [HALF_W-1:0] status_reg;
    logic [HALF_W-1:0] status_hw;
    logic [HALF_W-1:0] status_sw;
    logic [HALF_W-1:0] status_next;
    logic [DATA_W-1:0] ptr_reg;
    logic [DATA_W-1:0] int_sel_reg;
    logic [DATA_W-1:0] branch_sel_reg;
    logic [DATA_W-1:0] wait_sel_reg;
    chan_state_t       state_reg;
    chan_state_t       state_next;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // RULE_03 host adds base
    offset_decoder u_host_dec (
        .addr        (host_req.addr),
        .base        (CHANNEL_BASE),
        .bare_offset (1'b0),
        .hit         (host_hit),
        .idx         (host_idx)
    );

    // RULE_02 command key choice
    offset_decoder u_cmd_dec (
        .addr        (cmd_req.addr),
        .base        (CHANNEL_BASE),
        .bare_offset (cmd_regs_space),
        .hit         (cmd_hit),
        .idx         (cmd_idx)
    );

    // ------------------------------------------------------------
    // Access selection
    // ------------------------------------------------------------
    always_comb begin
        host_take = clk_en && host_sel && host_hit;
        cmd_take  = clk_en && cmd_sel && cmd_hit && !host_sel;
        acc_take  = host_take || cmd_take;
        acc_wr    = host_take ? host_req.wr : cmd_req.wr;
        acc_idx   = host_take ? host_idx : cmd_idx;
        acc_wdata = host_take ? host_req.wdata : cmd_req.wdata;
        // RULE_01 register decode
        // RULE_08 control port only
        ctrl_write = acc_take && acc_wr && (acc_idx == IDX_CONTROL);
        ptr_write  = acc_take && acc_wr && (acc_idx == IDX_CMD_PTR);
    end

    // ------------------------------------------------------------
    // Status update
    // ------------------------------------------------------------
    always_comb begin
        status_hw = status_reg;
        // RULE_18 wake cleared
        if (eng_evt.fetch_done) begin
            status_hw[BIT_WAKE] = 1'b0;
        end
        if (eng_evt.flush_done) begin
            status_hw[BIT_FLUSH] = 1'b0;
        end
    end

    // RULE_06 mask upper half
    masked_update u_mask (
        .cur              (status_hw),
        .write_bit_mask   (acc_wdata[DATA_W-1:MASK_LSB]),
        .write_bit_values (acc_wdata[HALF_W-1:0]),
        .nxt              (status_sw)
    );

    always_comb begin
        // RULE_10 status writes dropped
        status_next = ctrl_write ? status_sw : status_hw;
        // RULE_19 fatal cleared on abort
        if (status_reg[BIT_GO] && !status_next[BIT_GO]) begin
            status_next[BIT_FATAL] = 1'b0;
        end
        if (eng_evt.fatal && status_reg[BIT_GO]) begin
            status_next[BIT_FATAL] = 1'b1;
        end
        if (eng_evt.branch_done) begin
            status_next[BIT_BT] = eng_evt.branch_taken;
        end
        // RULE_17 executing follows state
        status_next[BIT_EXEC] = (state_next == CH_RUNNING);
    end

    // ------------------------------------------------------------
    // Channel state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CH_STOPPED: begin
                // RULE_16 go starts channel
                if (status_next[BIT_GO] && !status_next[BIT_FATAL]) begin
                    state_next = status_next[BIT_HOLD] ? CH_PAUSED : CH_RUNNING;
                end
            end
            CH_RUNNING: begin
                if (!status_next[BIT_GO] || status_next[BIT_FATAL]) begin
                    state_next = CH_STOPPED;
                end else if (status_next[BIT_HOLD]) begin
                    state_next = CH_PAUSED;
                end else if (eng_evt.stop_done) begin
                    state_next = CH_IDLE;
                end
            end
            CH_PAUSED: begin
                // RULE_17 resume on release
                if (!status_next[BIT_GO]) begin
                    state_next = CH_STOPPED;
                end else if (!status_next[BIT_HOLD]) begin
                    state_next = CH_RUNNING;
                end
            end
            CH_IDLE: begin
                // RULE_18 wake refetch
                if (!status_next[BIT_GO]) begin
                    state_next = CH_STOPPED;
                end else if (status_next[BIT_HOLD]) begin
                    state_next = CH_PAUSED;
                end else if (status_next[BIT_WAKE]) begin
                    state_next = CH_RUNNING;
                end
            end
            default: begin
                state_next = CH_STOPPED;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= CH_STOPPED;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // RULE_04 status resets zero
    // RULE_09 control bits visible
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= STATUS_RESET;
        end else if (clk_en) begin
            status_reg <= status_next;
        end
    end

    // ------------------------------------------------------------
    // Pointer and select registers
    // ------------------------------------------------------------
    // RULE_05 store when idle
    // RULE_13 command list location
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg <= ZERO_WORD;
        end else if (ptr_write && !status_reg[BIT_EXEC]) begin
            ptr_reg <= acc_wdata & PTR_ALIGN_MASK;
        end
    end

    // RULE_05 selects always stored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            int_sel_reg    <= ZERO_WORD;
            branch_sel_reg <= ZERO_WORD;
            wait_sel_reg   <= ZERO_WORD;
        end else if (acc_take && acc_wr) begin
            if (acc_idx == IDX_INT_SEL) begin
                int_sel_reg <= acc_wdata;
            end
            if (acc_idx == IDX_BRANCH_SEL) begin
                branch_sel_reg <= acc_wdata;
            end
            if (acc_idx == IDX_WAIT_SEL) begin
                wait_sel_reg <= acc_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] read_word(input logic [IDX_W-1:0] i);
        case (i)
            // RULE_12 upper half zero
            IDX_STATUS:     read_word = {STATUS_PAD, status_reg};
            IDX_CMD_PTR:    read_word = ptr_reg;
            IDX_INT_SEL:    read_word = int_sel_reg;
            IDX_BRANCH_SEL: read_word = branch_sel_reg;
            IDX_WAIT_SEL:   read_word = wait_sel_reg;
            // RULE_04 control reads zero
            // RULE_15 reserved reads zero
            default:        read_word = ZERO_WORD;
        endcase
    endfunction

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            host_ack   <= 1'b0;
            host_rdata <= ZERO_WORD;
        end else if (clk_en) begin
            host_ack   <= host_take;
            host_rdata <= (host_take && !host_req.wr) ? read_word(host_idx) : ZERO_WORD;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ack   <= 1'b0;
            cmd_rdata <= ZERO_WORD;
        end else if (clk_en) begin
            cmd_ack   <= cmd_take;
            cmd_rdata <= (cmd_take && !cmd_req.wr) ? read_word(cmd_idx) : ZERO_WORD;
        end
    end

    // ------------------------------------------------------------
    // Output assignment
    // ------------------------------------------------------------
    always_comb begin
        status_bits                = status_reg;
        executing_flag             = status_reg[BIT_EXEC];
        command_list_pointer_low   = ptr_reg;
        interrupt_condition_select = int_sel_reg;
        branch_condition_select    = branch_sel_reg;
        wait_condition_select      = wait_sel_reg;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence host_status_read;
        host_take && !host_req.wr && (host_idx == IDX_STATUS);
    endsequence

    sequence go_from_stop;
        ctrl_write && acc_wdata[MASK_LSB+BIT_GO] && acc_wdata[BIT_GO]
        && (state_reg == CH_STOPPED) && !status_reg[BIT_FATAL]
        && !status_next[BIT_HOLD] && !eng_evt.fatal;
    endsequence

    sequence hold_write;
        ctrl_write && acc_wdata[MASK_LSB+BIT_HOLD] && acc_wdata[BIT_HOLD];
    endsequence

    AST_CTRL_READ_ZERO: assert property ( // RULE_04
        host_take && !host_req.wr && (host_idx == IDX_CONTROL) |=> host_ack && host_rdata == '0)
        else $error("control port read returned nonzero");

    AST_STATUS_READ: assert property ( // RULE_12
        host_status_read |=> host_rdata == {STATUS_PAD, $past(status_reg)})
        else $error("status read mismatch or upper half set");

    AST_STATUS_WRITE_IGNORED: assert property ( // RULE_10
        host_take && host_req.wr && (host_idx == IDX_STATUS)
        |=> ((status_reg ^ $past(status_reg)) & SW_FREE_MASK) == '0)
        else $error("status write changed software bits");

    AST_MASKED_SELECT_BITS: assert property ( // RULE_07
        ctrl_write && clk_en |=> status_reg[SEL_W-1:0] ==
            (($past(acc_wdata[SEL_W-1:0]) & $past(acc_wdata[MASK_LSB+SEL_W-1:MASK_LSB]))
            | ($past(status_reg[SEL_W-1:0]) & ~$past(acc_wdata[MASK_LSB+SEL_W-1:MASK_LSB]))))
        else $error("masked write did not merge low bits");

    AST_PTR_HELD_WHEN_BUSY: assert property ( // RULE_05
        ptr_write && status_reg[BIT_EXEC] |=> $stable(ptr_reg))
        else $error("pointer changed while executing");

    AST_PTR_STORED_WHEN_IDLE: assert property ( // RULE_05
        ptr_write && !status_reg[BIT_EXEC] |=> ptr_reg == ($past(acc_wdata) & PTR_ALIGN_MASK))
        else $error("pointer not stored while idle");

    AST_GO_STARTS: assert property ( // RULE_16
        go_from_stop |=> executing_flag)
        else $error("go did not start channel");

    AST_HOLD_STOPS_EXEC: assert property ( // RULE_17
        hold_write |=> !executing_flag ##1 (!executing_flag || !status_reg[BIT_HOLD]))
        else $error("executing stayed set under hold");

    AST_WAKE_CLEARED: assert property ( // RULE_18
        eng_evt.fetch_done && clk_en && !ctrl_write |=> !status_reg[BIT_WAKE])
        else $error("wake not cleared after fetch");

    AST_FATAL_CLEARED: assert property ( // RULE_19
        $fell(status_reg[BIT_GO])
        |-> !executing_flag && (!status_reg[BIT_FATAL] || $past(eng_evt.fatal)))
        else $error("fatal flag survived abort");

    AST_FATAL_NOT_SOFT: assert property ( // RULE_11
        ctrl_write && !eng_evt.fatal && clk_en && !status_reg[BIT_GO]
        |=> $stable(status_reg[BIT_FATAL]))
        else $error("software set the fatal flag");

endmodule

// ### verif/host_bus_model.sv
// Host processor model issuing single-word register accesses
`timescale 1ns/1ps
module host_bus_model
    import dma_chan_pkg::*;
(
    input  wire logic clock,
    input  wire logic host_ack,
    output logic      host_sel,
    output reg_req_t  host_req,
    output int        miss_cnt
);
    logic [DATA_W-1:0] exp_q[$];

    initial begin
        host_sel = 1'b0;
        host_req = '0;
        miss_cnt = 0;
    end

    // ------------------------------------------------------------
    // Access
    // ------------------------------------------------------------
    // One pulse per access; answer due exactly one cycle later
    task automatic access(input logic wr, input logic [ADDR_W-1:0] addr,
                          input logic [DATA_W-1:0] wdata, input logic [DATA_W-1:0] exp,
                          input logic want_ack);
        if (want_ack) exp_q.push_back(exp);
        @(negedge clock);
        host_sel = 1'b1;
        host_req = {wr, addr, wdata};
        @(negedge clock);
        if (host_ack !== want_ack) miss_cnt++;
        host_sel = 1'b0;
        // Released bus shows inverted junk, never the last value
        host_req = ~host_req;
    endtask
endmodule

// ### verif/tb_dma_channel_regs.sv
// Self-checking bench of the channel register front end
`timescale 1ns/1ps
module tb_dma_channel_regs
    import dma_chan_pkg::*;
;
    localparam logic [ADDR_W-1:0] BASE = 32'h0000_2000;
    logic              clock;
    logic              rst_n;
    logic              clk_en;
    logic              host_sel;
    reg_req_t          host_req;
    logic [DATA_W-1:0] host_rdata;
    logic              host_ack;
    logic              cmd_sel;
    logic              cmd_regs_space;
    reg_req_t          cmd_req;
    logic [DATA_W-1:0] cmd_rdata;
    logic              cmd_ack;
    engine_evt_t       eng_evt;
    logic [HALF_W-1:0] status_bits;
    logic              executing_flag;
    logic [DATA_W-1:0] ptr_out;
    logic [DATA_W-1:0] sel_out[3];
    logic [DATA_W-1:0] cmd_q[$];
    logic [DATA_W-1:0] rv[3];
    logic [DATA_W-1:0] pv;
    int                miss_cnt;
    int                err_total;
    int                comparisons;

    dma_channel_regs #(.CHANNEL_BASE(BASE)) dut (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .host_sel(host_sel),
        .host_req(host_req), .host_rdata(host_rdata), .host_ack(host_ack),
        .cmd_sel(cmd_sel), .cmd_regs_space(cmd_regs_space), .cmd_req(cmd_req),
        .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .eng_evt(eng_evt),
        .status_bits(status_bits), .executing_flag(executing_flag),
        .command_list_pointer_low(ptr_out), .interrupt_condition_select(sel_out[0]),
        .branch_condition_select(sel_out[1]), .wait_condition_select(sel_out[2]));

    host_bus_model host (.clock(clock), .host_ack(host_ack), .host_sel(host_sel),
                         .host_req(host_req), .miss_cnt(miss_cnt));

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report;
        chk("host_ack_count", 32'(miss_cnt), 32'h0);
        chk("host_queue_left", 32'(host.exp_q.size()), 32'h0);
        chk("cmd_queue_left", 32'(cmd_q.size()), 32'h0);
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Oldest expectation is matched against each answer
    always @(posedge clock) begin
        if (host_ack === 1'b1) begin
            if (host.exp_q.size() == 0) chk("host_extra_ack", 32'h1, 32'h0);
            else chk("host_rdata", host_rdata, host.exp_q.pop_front());
        end else chk("host_rdata_idle", host_rdata, ZERO_WORD);
        if (cmd_ack === 1'b1) begin
            if (cmd_q.size() == 0) chk("cmd_extra_ack", 32'h1, 32'h0);
            else chk("cmd_rdata", cmd_rdata, cmd_q.pop_front());
        end else chk("cmd_rdata_idle", cmd_rdata, ZERO_WORD);
    end

    // ------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------
    task automatic hw(input logic [31:0] ofs, input logic [31:0] d);
        host.access(1'b1, BASE + ofs, d, ZERO_WORD, 1'b1);
    endtask

    task automatic hr(input logic [31:0] ofs, input logic [31:0] e);
        host.access(1'b0, BASE + ofs, ZERO_WORD, e, 1'b1);
    endtask

    task automatic st(input logic [15:0] e, input logic ex);
        hr(OFS_STATUS, {STATUS_PAD, e});
        chk("status_bits", 32'(status_bits), 32'(e));
        chk("executing_flag", 32'(executing_flag), 32'(ex));
    endtask

    task automatic ctl(input logic [31:0] w, input logic [15:0] e, input logic ex);
        hw(OFS_CONTROL, w);
        st(e, ex);
    endtask

    task automatic cacc(input logic rs, input logic wr, input logic [31:0] a,
                        input logic [31:0] d, input logic [31:0] e);
        cmd_q.push_back(e);
        @(negedge clock);
        cmd_sel = 1'b1;
        cmd_regs_space = rs;
        cmd_req = {wr, a, d};
        @(negedge clock);
        chk("cmd_ack", 32'(cmd_ack), 32'h1);
        cmd_sel = 1'b0;
        cmd_req = ~cmd_req;
    endtask

    task automatic ev(input engine_evt_t e);
        @(negedge clock);
        eng_evt = e;
        @(negedge clock);
        eng_evt = '0;
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        chk("watchdog", 32'h1, 32'h0);
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        cmd_sel = 1'b0;
        cmd_regs_space = 1'b0;
        cmd_req = '0;
        eng_evt = '0;
        err_total = 0;
        comparisons = 0;
        rv[0] = $urandom(32'h0445d4f7);
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        st(16'h0000, 1'b0);
        hr(OFS_CONTROL, ZERO_WORD);
        for (int i = 0; i < 3; i++) begin
            rv[i] = $urandom;
            hw(OFS_INT_SEL + 32'(4 * i), rv[i]);
        end
        for (int i = 0; i < 3; i++) begin
            hr(OFS_INT_SEL + 32'(4 * i), rv[i]);
            chk("select_out", sel_out[i], rv[i]);
        end
        hw(OFS_RESERVED, $urandom);
        hr(OFS_RESERVED, ZERO_WORD);
        host.access(1'b0, BASE + REG_WINDOW, ZERO_WORD, ZERO_WORD, 1'b0);
        host.access(1'b0, OFS_STATUS, ZERO_WORD, ZERO_WORD, 1'b0);
        clk_en = 1'b0;
        host.access(1'b0, BASE + OFS_STATUS, ZERO_WORD, ZERO_WORD, 1'b0);
        clk_en = 1'b1;
        cacc(1'b1, 1'b0, OFS_INT_SEL, ZERO_WORD, rv[0]);
        cacc(1'b0, 1'b0, BASE + OFS_BRANCH_SEL, ZERO_WORD, rv[1]);
        cacc(1'b1, 1'b1, OFS_WAIT_SEL, 32'h5a5a_0f0f, ZERO_WORD);
        hr(OFS_WAIT_SEL, 32'h5a5a_0f0f);
        ctl(32'h00ff_00a5, 16'h00a5, 1'b0);
        ctl(32'h000f_005a, 16'h00aa, 1'b0);
        ctl(32'h0f00_0f00, 16'h00aa, 1'b0);
        hw(OFS_STATUS, 32'hffff_ffff);
        st(16'h00aa, 1'b0);
        pv = $urandom;
        hw(OFS_CMD_PTR, pv);
        hr(OFS_CMD_PTR, pv & PTR_ALIGN_MASK);
        // Go only after the pointer is loaded
        ctl(32'h8000_8000, 16'h84aa, 1'b1);
        hw(OFS_CMD_PTR, ~pv);
        hr(OFS_CMD_PTR, pv & PTR_ALIGN_MASK);
        chk("pointer_out", ptr_out, pv & PTR_ALIGN_MASK);
        ctl(32'h4000_4000, 16'hc0aa, 1'b0);
        ctl(32'h4000_0000, 16'h84aa, 1'b1);
        ctl(32'h1000_0000, 16'h84aa, 1'b1);
        ctl(32'h1000_1000, 16'h94aa, 1'b1);
        ev(6'b100000);
        st(16'h84aa, 1'b1);
        ev(6'b000100);
        st(16'h88aa, 1'b0);
        ctl(32'h8000_0000, 16'h00aa, 1'b0);
        ctl(32'h8000_8000, 16'h84aa, 1'b1);
        ev(6'b001000);
        st(16'h80aa, 1'b0);
        ctl(32'h1000_1000, 16'h94aa, 1'b1);
        ev(6'b100011);
        st(16'h85aa, 1'b1);
        ctl(32'h2000_2000, 16'ha5aa, 1'b1);
        ev(6'b010000);
        st(16'h85aa, 1'b1);
        ctl(32'h8000_0000, 16'h01aa, 1'b0);
        @(negedge clock);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        st(16'h0000, 1'b0);
        repeat (3) @(negedge clock);
        final_report();
    end
endmodule
